// ==== rtl/mcp_pkg.sv ====
// constants and types shared by the multi-channel feedback controller
package mcp_pkg;

    // -------------------------------------------------------------
    // geometry and number format
    // -------------------------------------------------------------
    localparam int NUM_LOOPS = 8;
    localparam int FRAC_BITS = 16;

    // -------------------------------------------------------------
    // register map
    // -------------------------------------------------------------
    localparam logic [11:0] GCTRL_OFS   = 12'h000;
    localparam logic [11:0] STATUS_OFS  = 12'h004;
    localparam logic [2:0]  LOOP_REGION = 3'h1;
    localparam logic [3:0]  IDX_CTRL    = 4'h0;
    localparam logic [3:0]  IDX_SETPT   = 4'h1;
    localparam logic [3:0]  IDX_DEADZ   = 4'h2;
    localparam logic [3:0]  IDX_PGAIN   = 4'h3;
    localparam logic [3:0]  IDX_IGAIN   = 4'h4;
    localparam logic [3:0]  IDX_DGAIN   = 4'h5;
    localparam logic [3:0]  IDX_OMIN    = 4'h6;
    localparam logic [3:0]  IDX_OMAX    = 4'h7;
    localparam logic [3:0]  IDX_TLO     = 4'h8;
    localparam logic [3:0]  IDX_THI     = 4'h9;
    localparam logic [3:0]  IDX_IVAL    = 4'hA;
    localparam logic [3:0]  IDX_OUTPUT  = 4'hB;
    localparam logic [3:0]  IDX_INTEG   = 4'hC;

    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int GCTRL_SW_BIT    = 0;
    localparam int GCTRL_FORCE_BIT = 1;
    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_LIM_BIT    = 1;

    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic [31:0] IVAL_RST   = 32'h0000_03E8;
    localparam logic [31:0] TBL_LO_RST = 32'h8000_0000;
    localparam logic [31:0] TBL_HI_RST = 32'h7FFF_FFFF;

    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int TICK_NS       = 1000000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    // milliseconds to Q16.16 seconds: 65536 * 65.536
    localparam logic [31:0] DT_SCALE = 32'h0041_8937;

    typedef enum logic {
        ST_IDLE,
        ST_EXEC
    } mcp_fsm_t;

endpackage

// ==== rtl/mcp_calc.sv ====
// combinational arithmetic of one control loop execution
`timescale 1ns/1ns
`default_nettype none
module mcp_calc (
    input  wire logic signed [31:0] i_meas,
    input  wire logic signed [31:0] i_setpt,
    input  wire logic signed [31:0] i_dz,
    input  wire logic signed [31:0] i_pgain,
    input  wire logic signed [31:0] i_igain,
    input  wire logic signed [31:0] i_dgain,
    input  wire logic signed [31:0] i_omin,
    input  wire logic signed [31:0] i_omax,
    input  wire logic signed [31:0] i_tlo,
    input  wire logic signed [31:0] i_thi,
    input  wire logic signed [31:0] i_integ,
    input  wire logic signed [31:0] i_prev,
    input  wire logic signed [31:0] i_out_cur,
    input  wire logic        [31:0] i_ival,
    input  wire logic               i_lim_en,
    output logic signed      [31:0] o_out,
    output logic signed      [31:0] o_integ,
    output logic signed      [31:0] o_err,
    output logic signed      [31:0] o_p,
    output logic signed      [31:0] o_sum,
    output logic signed      [31:0] o_inc,
    output logic                    o_in_dz,
    output logic                    o_freeze,
    output logic                    o_clamped
);
    // -------------------------------------------------------------
    // saturating helpers, Q16.16
    // -------------------------------------------------------------
    function automatic logic signed [31:0] sat(input logic signed [63:0] v);
        if (v > 64'sh0000_0000_7FFF_FFFF) begin
            return 32'sh7FFF_FFFF;
        end
        if (v < 64'shFFFF_FFFF_8000_0000) begin
            return 32'sh8000_0000;
        end
        return v[31:0];
    endfunction

    function automatic logic signed [31:0] fmul(input logic signed [31:0] a,
                                                 input logic signed [31:0] b);
        logic signed [63:0] p;
        p = 64'(a) * 64'(b);
        return sat(p >>> mcp_pkg::FRAC_BITS);
    endfunction

    // -------------------------------------------------------------
    // datapath
    // -------------------------------------------------------------
    always_comb begin
        logic signed [63:0] dt;
        logic signed [63:0] diff;
        logic signed [63:0] rate;
        logic signed [31:0] lo;
        logic signed [31:0] hi;
        dt   = 64'sh0;
        diff = 64'sh0;
        rate = 64'sh0;
        lo   = i_lim_en ? i_omin : i_tlo;
        hi   = i_lim_en ? i_omax : i_thi;
        o_err = sat(64'(i_meas) - 64'(i_setpt));
        o_in_dz = (64'(o_err) <= 64'(i_dz)) && (64'(o_err) >= -64'(i_dz));
        dt = $signed((64'(i_ival) * 64'(mcp_pkg::DT_SCALE)) >> mcp_pkg::FRAC_BITS);
        // a zero interval would divide by zero; dt becomes one LSB, while the timer runs it on every 1 ms tick
        if (dt == 64'sh0) begin
            dt = 64'sh1;
        end
        o_inc = sat((64'(o_err) * dt) >>> mcp_pkg::FRAC_BITS);
        o_freeze = ((i_out_cur >= hi) && (o_inc > 32'sh0))
                || ((i_out_cur <= lo) && (o_inc < 32'sh0));
        o_integ = o_freeze ? i_integ : sat(64'(i_integ) + 64'(o_inc));
        o_p = fmul(o_err, i_pgain);
        diff = 64'(o_err) - 64'(i_prev);
        rate = (diff <<< mcp_pkg::FRAC_BITS) / dt;
        o_sum = sat(64'(o_p) + 64'(fmul(o_integ, i_igain))
                + 64'(fmul(sat(rate), i_dgain)));
        o_clamped = i_lim_en && ((o_sum < lo) || (o_sum > hi));
        o_out = o_sum;
        if (i_lim_en && (o_sum < lo)) begin
            o_out = lo;
        end else if (i_lim_en && (o_sum > hi)) begin
            o_out = hi;
        end
        // inside the dead zone the output and the integral hold and o_clamped clears; o_err still goes out as the new previous error
        if (o_in_dz) begin
            o_out     = i_out_cur;
            o_integ   = i_integ;
            o_clamped = 1'b0;
        end
    end

endmodule
`default_nettype wire

// ==== rtl/mcp_timer.sv ====
// per-loop execution interval timers on a shared millisecond tick
`timescale 1ns/1ns
`default_nettype none
module mcp_timer #(
    parameter int TICK_CYCLES = mcp_pkg::TICK_CYCLES
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst_b,
    input  wire logic [7:0]       i_run,
    input  wire logic [7:0][31:0] i_ival,
    output logic      [7:0]       o_due
);
    typedef struct packed {
        logic [31:0]       presc;
        logic [7:0][31:0]  cnt;
        logic [7:0]        due;
    } mcp_tmr_t;

    mcp_tmr_t st_ff;
    mcp_tmr_t nxt_st;
    logic     tick;

    assign tick  = (st_ff.presc == 32'(TICK_CYCLES - 1));
    assign o_due = st_ff.due;

    // -------------------------------------------------------------
    // counters
    // -------------------------------------------------------------
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.presc = tick ? 32'h0 : st_ff.presc + 32'h1;
        nxt_st.due   = 8'h00;
        for (int k = 0; k < mcp_pkg::NUM_LOOPS; k++) begin
            if (!i_run[k]) begin
                nxt_st.cnt[k] = 32'h0;
            end else if (tick) begin
                if (st_ff.cnt[k] + 32'h1 >= i_ival[k]) begin
                    nxt_st.due[k] = 1'b1;
                    nxt_st.cnt[k] = 32'h0;
                end else begin
                    nxt_st.cnt[k] = st_ff.cnt[k] + 32'h1;
                end
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    due_on_tick_a: assert property ((|st_ff.due) |-> $past(tick))
        else $error("loop came due without a millisecond tick");
    run_gate_a: assert property ((st_ff.due & ~$past(i_run)) == 8'h00)
        else $error("stopped loop came due");

endmodule
`default_nettype wire

// ==== rtl/mcp_top.sv ====
// eight-loop feedback controller with its register file on APB
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - eight loops, each own settings and state
// - disabled loop computes nothing; enabled runs periodically
// - one execution per programmed interval
// - feedback is analog, same units as setpoint
// - no correction inside dead zone
// - limiting clamps output to min and max
// - integral frozen while output sits at limit
// - without limiting, table bounds stop integral
// - nothing runs while control switch disabled
// - option forces outputs off when switch disabled
// - output is sum of three terms
// - proportional is error times proportional gain
// - integral is summed error times integral gain
// - derivative is error slope times derivative gain
module mcp_top #(
    parameter int TICK_CYCLES = mcp_pkg::TICK_CYCLES
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst_b,
    input  wire logic             i_psel,
    input  wire logic             i_penable,
    input  wire logic             i_pwrite,
    input  wire logic [11:0]      i_paddr,
    input  wire logic [31:0]      i_pwdata,
    output logic      [31:0]      o_prdata,
    output logic                  o_pready,
    output logic                  o_pslverr,
    input  wire logic [7:0][31:0] i_meas,
    output logic      [7:0][31:0] o_out,
    output logic      [7:0]       o_out_valid
);
    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef struct packed {
        mcp_pkg::mcp_fsm_t st;
        logic [2:0]        idx;
        logic [7:0]        pend;
        logic              sw_en;
        logic              force_off;
        logic [7:0]        en;
        logic [7:0]        lim_en;
        logic [7:0]        clamped;
        logic [7:0]        vld;
        logic [7:0][31:0]  setpt;
        logic [7:0][31:0]  dz;
        logic [7:0][31:0]  pg;
        logic [7:0][31:0]  ig;
        logic [7:0][31:0]  dg;
        logic [7:0][31:0]  omin;
        logic [7:0][31:0]  omax;
        logic [7:0][31:0]  tlo;
        logic [7:0][31:0]  thi;
        logic [7:0][31:0]  ival;
        logic [7:0][31:0]  out;
        logic [7:0][31:0]  integ;
        logic [7:0][31:0]  prev;
        logic [7:0][31:0]  drv;
        logic [31:0]       rdata;
        logic              slverr;
    } mcp_state_t;

    mcp_state_t        st_ff;
    mcp_state_t        nxt_st;
    logic [7:0]        due;
    logic [7:0]        run;
    logic [2:0]        sel;
    logic signed [31:0] c_out;
    logic signed [31:0] c_integ;
    logic signed [31:0] c_err;
    logic signed [31:0] c_p;
    logic signed [31:0] c_sum;
    logic signed [31:0] c_inc;
    logic               c_dz;
    logic               c_freeze;
    logic               c_clamp;

    assign sel = st_ff.idx;
    // loops only run with the global switch on
    assign run = st_ff.en & {8{st_ff.sw_en}};

    assign o_pready    = i_psel & i_penable;
    assign o_prdata    = st_ff.rdata;
    assign o_pslverr   = st_ff.slverr & i_psel & i_penable;
    assign o_out       = st_ff.drv;
    assign o_out_valid = st_ff.vld;

    // -------------------------------------------------------------
    // interval timers and shared arithmetic
    // -------------------------------------------------------------
    mcp_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .i_run   (run),
        .i_ival  (st_ff.ival),
        .o_due   (due)
    );

    // one datapath serves all loops in turn; costs two cycles per loop, saves seven copies
    mcp_calc u_calc (
        .i_meas    (i_meas[sel]),
        .i_setpt   (st_ff.setpt[sel]),
        .i_dz      (st_ff.dz[sel]),
        .i_pgain   (st_ff.pg[sel]),
        .i_igain   (st_ff.ig[sel]),
        .i_dgain   (st_ff.dg[sel]),
        .i_omin    (st_ff.omin[sel]),
        .i_omax    (st_ff.omax[sel]),
        .i_tlo     (st_ff.tlo[sel]),
        .i_thi     (st_ff.thi[sel]),
        .i_integ   (st_ff.integ[sel]),
        .i_prev    (st_ff.prev[sel]),
        .i_out_cur (st_ff.out[sel]),
        .i_ival    (st_ff.ival[sel]),
        .i_lim_en  (st_ff.lim_en[sel]),
        .o_out     (c_out),
        .o_integ   (c_integ),
        .o_err     (c_err),
        .o_p       (c_p),
        .o_sum     (c_sum),
        .o_inc     (c_inc),
        .o_in_dz   (c_dz),
        .o_freeze  (c_freeze),
        .o_clamped (c_clamp)
    );

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        logic [2:0]  ln;
        logic [3:0]  ri;
        logic        hit_g;
        logic        hit_l;
        logic        wr;
        logic [31:0] rd;
        ln     = i_paddr[8:6];
        ri     = i_paddr[5:2];
        hit_g  = (i_paddr[11:2] == mcp_pkg::GCTRL_OFS[11:2])
              || (i_paddr[11:2] == mcp_pkg::STATUS_OFS[11:2]);
        hit_l  = (i_paddr[11:9] == mcp_pkg::LOOP_REGION) && (ri <= mcp_pkg::IDX_INTEG);
        wr     = i_psel & i_penable & i_pwrite & ~st_ff.slverr;
        rd     = 32'h0000_0000;
        nxt_st = st_ff;
        nxt_st.vld = 8'h00;

        // setup phase: decode and latch read data
        if (i_psel && !i_penable) begin
            if (hit_g && i_paddr[2]) begin
                rd = {16'h0000, st_ff.clamped, run};
            end else if (hit_g) begin
                rd = {30'h0000_0000, st_ff.force_off, st_ff.sw_en};
            end else if (hit_l) begin
                case (ri)
                    mcp_pkg::IDX_CTRL:   rd = {30'h0000_0000, st_ff.lim_en[ln], st_ff.en[ln]};
                    mcp_pkg::IDX_SETPT:  rd = st_ff.setpt[ln];
                    mcp_pkg::IDX_DEADZ:  rd = st_ff.dz[ln];
                    mcp_pkg::IDX_PGAIN:  rd = st_ff.pg[ln];
                    mcp_pkg::IDX_IGAIN:  rd = st_ff.ig[ln];
                    mcp_pkg::IDX_DGAIN:  rd = st_ff.dg[ln];
                    mcp_pkg::IDX_OMIN:   rd = st_ff.omin[ln];
                    mcp_pkg::IDX_OMAX:   rd = st_ff.omax[ln];
                    mcp_pkg::IDX_TLO:    rd = st_ff.tlo[ln];
                    mcp_pkg::IDX_THI:    rd = st_ff.thi[ln];
                    mcp_pkg::IDX_IVAL:   rd = st_ff.ival[ln];
                    mcp_pkg::IDX_OUTPUT: rd = st_ff.out[ln];
                    mcp_pkg::IDX_INTEG:  rd = st_ff.integ[ln];
                    default:             rd = 32'h0000_0000;
                endcase
            end
            nxt_st.rdata  = rd;
            nxt_st.slverr = ~(hit_g | hit_l);
        end

        // access phase: writes; STATUS and the loop output and integral words are read only
        if (wr && hit_g && !i_paddr[2]) begin
            nxt_st.sw_en     = i_pwdata[mcp_pkg::GCTRL_SW_BIT];
            nxt_st.force_off = i_pwdata[mcp_pkg::GCTRL_FORCE_BIT];
        end else if (wr && hit_l) begin
            case (ri)
                mcp_pkg::IDX_CTRL: begin
                    nxt_st.en[ln]     = i_pwdata[mcp_pkg::CTRL_EN_BIT];
                    nxt_st.lim_en[ln] = i_pwdata[mcp_pkg::CTRL_LIM_BIT];
                end
                mcp_pkg::IDX_SETPT: nxt_st.setpt[ln] = i_pwdata;
                mcp_pkg::IDX_DEADZ: nxt_st.dz[ln]    = i_pwdata;
                mcp_pkg::IDX_PGAIN: nxt_st.pg[ln]    = i_pwdata;
                mcp_pkg::IDX_IGAIN: nxt_st.ig[ln]    = i_pwdata;
                mcp_pkg::IDX_DGAIN: nxt_st.dg[ln]    = i_pwdata;
                mcp_pkg::IDX_OMIN:  nxt_st.omin[ln]  = i_pwdata;
                mcp_pkg::IDX_OMAX:  nxt_st.omax[ln]  = i_pwdata;
                mcp_pkg::IDX_TLO:   nxt_st.tlo[ln]   = i_pwdata;
                mcp_pkg::IDX_THI:   nxt_st.thi[ln]   = i_pwdata;
                mcp_pkg::IDX_IVAL:  nxt_st.ival[ln]  = i_pwdata;
                default: begin
                end
            endcase
        end

        // a new due sets the pending bit even in the cycle it is consumed
        nxt_st.pend = (st_ff.pend | due) & run;

        case (st_ff.st)
            mcp_pkg::ST_IDLE: begin
                if (|(st_ff.pend & run)) begin
                    for (int k = mcp_pkg::NUM_LOOPS - 1; k >= 0; k--) begin
                        if (st_ff.pend[k] && run[k]) begin
                            nxt_st.idx = 3'(k);
                        end
                    end
                    nxt_st.st = mcp_pkg::ST_EXEC;
                end
            end
            mcp_pkg::ST_EXEC: begin
                nxt_st.out[sel]     = c_out;
                nxt_st.integ[sel]   = c_integ;
                nxt_st.prev[sel]    = c_err;
                nxt_st.clamped[sel] = c_clamp;
                nxt_st.vld[sel]     = 1'b1;
                nxt_st.pend[sel]    = due[sel] & run[sel];
                nxt_st.st           = mcp_pkg::ST_IDLE;
            end
            default: nxt_st.st = mcp_pkg::ST_IDLE;
        endcase

        // drivers lag the loop results by one cycle
        nxt_st.drv = (!st_ff.sw_en && st_ff.force_off) ? '0 : st_ff.out;
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_ff      <= '0;
            st_ff.ival <= {8{mcp_pkg::IVAL_RST}};
            st_ff.tlo  <= {8{mcp_pkg::TBL_LO_RST}};
            st_ff.thi  <= {8{mcp_pkg::TBL_HI_RST}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    switch_gates_a: assert property (
        (st_ff.st == mcp_pkg::ST_EXEC) |-> $past(st_ff.sw_en))
        else $error("loop executed with control switch off");

    force_off_a: assert property (
        (!st_ff.sw_en && st_ff.force_off) |=> (o_out == '0))
        else $error("outputs not forced off");

    clamp_range_a: assert property (
        (st_ff.st == mcp_pkg::ST_EXEC && st_ff.lim_en[sel] && !c_dz
         && $signed(st_ff.omin[sel]) <= $signed(st_ff.omax[sel]))
        |=> ($signed(st_ff.out[$past(sel)]) >= $signed(st_ff.omin[$past(sel)]))
         && ($signed(st_ff.out[$past(sel)]) <= $signed(st_ff.omax[$past(sel)])))
        else $error("limited output left its range");

    dead_zone_a: assert property (
        (st_ff.st == mcp_pkg::ST_EXEC && c_dz)
        |=> (st_ff.out[$past(sel)] == $past(st_ff.out[sel]))
         && (st_ff.integ[$past(sel)] == $past(st_ff.integ[sel])))
        else $error("output corrected inside dead zone");

    term_sum_a: assert property (
        (st_ff.st == mcp_pkg::ST_EXEC && !c_dz && !st_ff.lim_en[sel])
        |=> $signed(st_ff.out[$past(sel)]) == $past(c_sum))
        else $error("unlimited output is not the term sum");

    prop_only_a: assert property (
        (st_ff.st == mcp_pkg::ST_EXEC && !c_dz && !st_ff.lim_en[sel]
         && st_ff.ig[sel] == 32'h0 && st_ff.dg[sel] == 32'h0)
        |=> $signed(st_ff.out[$past(sel)]) == $past(c_p))
        else $error("proportional term wrong");

    windup_hold_a: assert property (
        (st_ff.st == mcp_pkg::ST_EXEC && c_freeze)
        |=> st_ff.integ[$past(sel)] == $past(st_ff.integ[sel]))
        else $error("integral moved while output at limit");

    table_bound_a: assert property (
        (st_ff.st == mcp_pkg::ST_EXEC && !st_ff.lim_en[sel] && !c_dz
         && $signed(st_ff.out[sel]) >= $signed(st_ff.thi[sel]) && c_inc > 32'sh0)
        |=> st_ff.integ[$past(sel)] == $past(st_ff.integ[sel]))
        else $error("integral passed table high bound");

    due_pending_a: assert property (
        (|(due & run)) |=> ((st_ff.pend & $past(due & run)) == $past(due & run)))
        else $error("execution request lost");

    one_exec_a: assert property (
        (st_ff.st == mcp_pkg::ST_EXEC) |=> (st_ff.st == mcp_pkg::ST_IDLE)
         && $onehot(st_ff.vld))
        else $error("execution did not finish in one cycle");

endmodule
`default_nettype wire

// ==== testbench/mcp_plant_model.sv ====
// process sensors and actuator points around the controller
`timescale 1ns/1ns
`default_nettype none
module mcp_plant_model (
    input  wire logic             i_mclk,
    input  wire logic [7:0][31:0] i_level,
    input  wire logic             i_clr,
    input  wire logic [7:0]       i_out_valid,
    output logic      [7:0][31:0] o_meas,
    output logic      [15:0]      o_runs
);
    // analog feedback, same units as setpoint
    always_ff @(posedge i_mclk) o_meas <= i_level;
    // actuator side counts updates of loop 0
    always_ff @(posedge i_mclk) o_runs <= i_clr ? 16'h0000 : o_runs + 16'(i_out_valid[0]);
endmodule
`default_nettype wire

// ==== testbench/mcp_top_tb.sv ====
// self-checking bench for the eight-loop controller
`timescale 1ns/1ns
`default_nettype none
module mcp_top_tb;
    logic             i_mclk, i_rst_b, psel, pen, pwr, pclr, pready, pslverr, err;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata, rd;
    logic [7:0][31:0] lvl, meas, out;
    logic [7:0]       vld;
    logic [15:0]      runs;
    int               bad_count, checks;
    mcp_top #(.TICK_CYCLES(10)) i_mcp_top (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_meas(meas), .o_out(out), .o_out_valid(vld));
    mcp_plant_model i_mcp_plant_model (.i_mclk(i_mclk), .i_level(lvl),
        .i_clr(pclr), .i_out_valid(vld), .o_meas(meas), .o_runs(runs));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_mclk);
        pen <= 1'b1;
        do begin
            @(posedge i_mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            bad_count++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // loop 0 register address
    function automatic logic [11:0] la(input logic [3:0] ix);
        return 12'h200 + {6'h00, ix, 2'b00};
    endfunction
    task automatic wexec();
        int n;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (vld[0] !== 1'b1 && n < 2000);
        if (n >= 2000) bad_count++;
        @(posedge i_mclk);
        #1;
    endtask
    task automatic wrap_up();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    initial begin
        #(40000 * 8);
        bad_count++;
        wrap_up();
    end
    task automatic t_regs();
        apb(1'b0, 12'h2E8, 32'h0);
        chk(rd, mcp_pkg::IVAL_RST);
        apb(1'b0, la(mcp_pkg::IDX_TLO), 32'h0);
        chk(rd, mcp_pkg::TBL_LO_RST);
        apb(1'b0, 12'h234, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask
    // loop 0: unit proportional gain, 2 ms interval, switch still off
    task automatic t_switch();
        apb(1'b1, la(mcp_pkg::IDX_PGAIN), 32'h0001_0000);
        apb(1'b1, la(mcp_pkg::IDX_IVAL), 32'h2);
        apb(1'b1, la(mcp_pkg::IDX_CTRL), 32'h1);
        pclr <= 1'b1;
        repeat (100) @(posedge i_mclk);
        chk(runs, 16'h0);
        pclr <= 1'b0;
        apb(1'b1, 12'h000, 32'h1);
        wexec();
        chk(out[0], 32'h0005_0000);
    endtask
    task automatic t_period();
        pclr <= 1'b1;
        @(posedge i_mclk);
        pclr <= 1'b0;
        // 20 cycles per run, one run of slack for phase
        repeat (200) @(posedge i_mclk);
        chk(32'(runs >= 9 && runs <= 11), 32'h1);
    endtask
    task automatic t_dead_zone();
        apb(1'b1, la(mcp_pkg::IDX_DEADZ), 32'h000A_0000);
        apb(1'b1, la(mcp_pkg::IDX_PGAIN), 32'h0002_0000);
        wexec();
        wexec();
        chk(out[0], 32'h0005_0000);
        apb(1'b1, la(mcp_pkg::IDX_DEADZ), 32'h0);
        wexec();
        wexec();
        chk(out[0], 32'h000A_0000);
    endtask
    task automatic t_clamp();
        apb(1'b1, la(mcp_pkg::IDX_OMAX), 32'h0002_0000);
        apb(1'b1, la(mcp_pkg::IDX_CTRL), 32'h3);
        wexec();
        wexec();
        chk(out[0], 32'h0002_0000);
    endtask
    // table high below the output stops the integral while limiting is off
    task automatic t_table();
        logic [31:0] held;
        apb(1'b1, la(mcp_pkg::IDX_THI), 32'h0001_0000);
        apb(1'b1, la(mcp_pkg::IDX_CTRL), 32'h1);
        wexec();
        apb(1'b0, la(mcp_pkg::IDX_INTEG), 32'h0);
        held = rd;
        wexec();
        apb(1'b0, la(mcp_pkg::IDX_INTEG), 32'h0);
        chk(rd, held);
        chk(out[0], 32'h000A_0000);
    endtask
    task automatic t_force_off();
        apb(1'b1, 12'h000, 32'h2);
        repeat (5) @(posedge i_mclk);
        chk(out[0], 32'h0);
    endtask
    initial begin
        {i_rst_b, psel, pen, pwr, pclr, paddr, pwdata} = '0;
        lvl = '0;
        lvl[0] = 32'h0005_0000;
        repeat (8) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        t_regs();
        t_switch();
        t_period();
        t_dead_zone();
        t_clamp();
        t_table();
        t_force_off();
        wrap_up();
    end
endmodule
`default_nettype wire
